//--- dtcru_pkg.sv
package dtcru_pkg;
	localparam int TW = 16;
	// Register byte offsets
	localparam logic [7:0] OFS_AUX_CTRL = 8'h00;
	localparam logic [7:0] OFS_CORE_CTRL = 8'h04;
	localparam logic [7:0] OFS_AUX_CNT = 8'h08;
	localparam logic [7:0] OFS_CORE_CNT = 8'h0c;
	localparam logic [7:0] OFS_CAPTURE_RELOAD_REG = 8'h10;
	localparam logic [7:0] OFS_CAP_CTRL = 8'h14;
	// Timer control fields
	localparam int F_PSEL = 0;
	localparam int F_MODE = 3;
	localparam int F_RUN = 5;
	localparam int F_DIR = 6;
	localparam int F_EXTDIR = 7;
	localparam int F_GATEPOL = 8;
	localparam int F_AUXCLK = 9;
	localparam int F_RELOAD = 10;
	localparam int F_OUTEN = 11;
	// Capture control fields
	localparam int F_CEDGE = 0;
	localparam int F_CSRC = 2;
	localparam int F_CCLR = 4;
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;
	localparam logic [2:0] PRE_BASE_LOG2 = 3'h2;
	localparam logic [1:0] AXI_OKAY = 2'h0;
	localparam logic [1:0] AXI_SLVERR = 2'h2;
	typedef enum logic [1:0] {
		DTCRU_TIMER,
		DTCRU_GATED,
		DTCRU_COUNTER
	} dtcru_mode_e;
	typedef struct packed {
		logic [TW-1:0] value;
		logic [11:0] ctrl;
	} dtcru_timer_s;
	typedef enum {DTCRU_W_IDLE, DTCRU_W_RESP} dtcru_wst_e;
endpackage : dtcru_pkg

//--- dtcru_top.sv
// Decided for this implementation: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
// Function
// - Auxiliary timer, core timer and one shared capture/reload register.
// - Each timer counts prescaled CPU clock or external input pin events.
// - Three-bit prescale select; 000b divides by 4, each code doubles, to 512.
// - Direction from software bit, optionally inverted by direction pin level (XOR).
// - Core toggle latch inverts on each core overflow or underflow.
// - Toggle latch can clock the auxiliary timer and drive the output pin.
// - Core overflow/underflow events offered as clock to compare-unit timers.
// - With reload enabled, core over/underflow loads the capture/reload value.
// - Selected capture pin transition copies auxiliary timer into capture reg.
// - Optional clear of the auxiliary timer right after each capture.
// - Capture trigger also from peer count input, direction input, or both.
// - Gated timer mode on both timers using the same prescaler set.
// - Gated mode counts prescaled pulses only while gate pin is active.
// - Counter mode advances on both edges of the count input pin, or on toggle latch edges for aux.
module dtcru_top #(
	parameter int PSEL_W = 3 // Prescale select width
) (
	input wire logic aclk, // Clock
	input wire logic aresetn, // Sync reset, low
	input wire logic [7:0] s_axi_awaddr, // Write address
	input wire logic s_axi_awvalid, // Write address valid
	output logic s_axi_awready, // Write address ready
	input wire logic [31:0] s_axi_wdata, // Write data
	input wire logic [3:0] s_axi_wstrb, // Byte enables
	input wire logic s_axi_wvalid, // Write data valid
	output logic s_axi_wready, // Write data ready
	output logic [1:0] s_axi_bresp, // Write response
	output logic s_axi_bvalid, // Write response valid
	input wire logic s_axi_bready, // Response ready
	input wire logic [7:0] s_axi_araddr, // Read address
	input wire logic s_axi_arvalid, // Read address valid
	output logic s_axi_arready, // Read address ready
	output logic [31:0] s_axi_rdata, // Read data
	output logic [1:0] s_axi_rresp, // Read response
	output logic s_axi_rvalid, // Read data valid
	input wire logic s_axi_rready, // Read ready
	input wire logic aux_input_pin, // Aux count/gate input
	input wire logic aux_direction_input_pin, // Aux direction pin
	input wire logic core_input_pin, // Core count/gate input
	input wire logic core_direction_input_pin, // Core direction pin
	input wire logic capture_input_pin, // Capture trigger pin
	input wire logic peer_count_input, // Peer core timer count input
	input wire logic peer_direction_input, // Peer core direction input
	output logic toggle_output_pin, // Toggle latch output
	output logic compare_unit_clk // Core over/underflow pulse
);
	initial begin
		if (PSEL_W != 3) begin
			$error("dtcru_top: prescale select must be 3 bits");
		end
	end

	// Pin synchronisers: stage 1 is read only by stage 2
	logic [6:0] sync1, sync2, sync3;
	logic [6:0] next_sync1, next_sync2, next_sync3;
	logic [6:0] pins;
	assign pins = {peer_direction_input, peer_count_input, capture_input_pin,
		core_direction_input_pin, core_input_pin,
		aux_direction_input_pin, aux_input_pin};
	always_comb begin
		next_sync1 = pins;
		next_sync2 = sync1;
		next_sync3 = sync2;
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sync1 <= '0;
			sync2 <= '0;
			sync3 <= '0;
		end else begin
			sync1 <= next_sync1;
			sync2 <= next_sync2;
			sync3 <= next_sync3;
		end
	end
	logic [6:0] rise, fall;
	assign rise = sync2 & ~sync3;
	assign fall = ~sync2 & sync3;

	// Registers
	dtcru_pkg::dtcru_timer_s aux, core, next_aux, next_core;
	logic [15:0] capture_reload_reg, next_capture_reload_reg;
	// Write-side state sits here because the timer logic reads it
	logic aw_held, w_held, next_aw_held, next_w_held;
	logic [7:0] wr_addr, next_wr_addr;
	logic [31:0] wr_data, next_wr_data;
	logic wr_fire, next_bvalid;
	logic [1:0] next_bresp;
	logic [4:0] cap_ctrl, next_cap_ctrl;
	logic toggle_latch, next_toggle_latch;
	logic [8:0] prediv, next_prediv;
	logic comp_clk, next_comp_clk;

	function automatic logic pre_tick(input logic [8:0] div,
		input logic [8:0] nd, input logic [2:0] sel);
		logic [3:0] b;
		b = 4'(sel) + 4'(dtcru_pkg::PRE_BASE_LOG2) - 4'h1;
		pre_tick = div[b] & ~nd[b];
	endfunction : pre_tick

	function automatic logic ctick(input logic [11:0] c, input logic pt,
		input logic pin, input logic prise, input logic pfall,
		input logic alt, input logic alt_en);
		logic gate;
		gate = (pin == c[dtcru_pkg::F_GATEPOL]);
		ctick = 1'b0;
		if (c[dtcru_pkg::F_RUN]) begin
			unique case (c[dtcru_pkg::F_MODE +: 2])
				2'(dtcru_pkg::DTCRU_TIMER): ctick = pt;
				2'(dtcru_pkg::DTCRU_GATED): ctick = pt & gate;
				2'(dtcru_pkg::DTCRU_COUNTER):
					ctick = alt_en ? alt : (prise | pfall);
				default: ctick = 1'b0;
			endcase
		end
	endfunction : ctick

	function automatic logic cdir(input logic [11:0] c, input logic p);
		cdir = c[dtcru_pkg::F_EXTDIR] ? (c[dtcru_pkg::F_DIR] ^ p)
			: c[dtcru_pkg::F_DIR];
	endfunction : cdir

	logic aux_tick, core_tick, core_down, aux_down, core_wrap, cap_ev;
	logic tl_prev, tl_edge;
	logic [1:0] cedge;
	always_comb begin
		next_prediv = prediv + 9'h1;
		tl_edge = toggle_latch ^ tl_prev;
		core_tick = ctick(core.ctrl,
			pre_tick(prediv, next_prediv, core.ctrl[2:0]), sync3[2],
			rise[2], fall[2], 1'b0, 1'b0);
		aux_tick = ctick(aux.ctrl,
			pre_tick(prediv, next_prediv, aux.ctrl[2:0]), sync3[0],
			rise[0], fall[0], tl_edge,
			aux.ctrl[dtcru_pkg::F_AUXCLK]);
		core_down = cdir(core.ctrl, sync3[3]);
		aux_down = cdir(aux.ctrl, sync3[1]);
		core_wrap = core_tick & (core_down ? (core.value == 16'h0000)
			: (core.value == 16'hffff));
		cedge = cap_ctrl[dtcru_pkg::F_CEDGE +: 2];
		cap_ev = 1'b0;
		for (int i = 0; i < 3; i++) begin
			if ((i == 0) || cap_ctrl[dtcru_pkg::F_CSRC + i - 1]) begin
				cap_ev = cap_ev | (cedge[0] & rise[4 + i]) |
					(cedge[1] & fall[4 + i]);
			end
		end
		next_core = core;
		next_aux = aux;
		next_capture_reload_reg = capture_reload_reg;
		next_toggle_latch = toggle_latch ^ core_wrap;
		next_comp_clk = core_wrap;
		if (core_tick) begin
			next_core.value = core_down ? core.value - 16'h1
				: core.value + 16'h1;
		end
		if (core_wrap && core.ctrl[dtcru_pkg::F_RELOAD]) begin
			next_core.value = capture_reload_reg;
		end
		if (aux_tick) begin
			next_aux.value = aux_down ? aux.value - 16'h1
				: aux.value + 16'h1;
		end
		if (cap_ev) begin
			next_capture_reload_reg = aux.value;
			if (cap_ctrl[dtcru_pkg::F_CCLR]) begin
				next_aux.value = '0;
			end
		end
		next_cap_ctrl = cap_ctrl;
		if (wr_fire) begin
			unique case (wr_addr)
				dtcru_pkg::OFS_AUX_CTRL: next_aux.ctrl = wr_data[11:0];
				dtcru_pkg::OFS_CORE_CTRL: next_core.ctrl = wr_data[11:0];
				dtcru_pkg::OFS_AUX_CNT: next_aux.value = wr_data[15:0];
				dtcru_pkg::OFS_CORE_CNT: next_core.value = wr_data[15:0];
				dtcru_pkg::OFS_CAPTURE_RELOAD_REG: next_capture_reload_reg = wr_data[15:0];
				dtcru_pkg::OFS_CAP_CTRL: next_cap_ctrl = wr_data[4:0];
				default: ;
			endcase
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aux <= '0;
			core <= '0;
			capture_reload_reg <= '0;
			cap_ctrl <= '0;
			toggle_latch <= 1'b0;
			tl_prev <= 1'b0;
			prediv <= '0;
			comp_clk <= 1'b0;
			toggle_output_pin <= 1'b0;
		end else begin
			aux <= next_aux;
			core <= next_core;
			capture_reload_reg <= next_capture_reload_reg;
			cap_ctrl <= next_cap_ctrl;
			toggle_latch <= next_toggle_latch;
			tl_prev <= toggle_latch;
			prediv <= next_prediv;
			comp_clk <= next_comp_clk;
			toggle_output_pin <= next_toggle_latch &
				next_core.ctrl[dtcru_pkg::F_OUTEN];
		end
	end
	assign compare_unit_clk = comp_clk;

	// AXI4-Lite write: address and data in either order
	always_comb begin
		next_aw_held = aw_held;
		next_w_held = w_held;
		next_wr_addr = wr_addr;
		next_wr_data = wr_data;
		next_bvalid = s_axi_bvalid;
		next_bresp = s_axi_bresp;
		wr_fire = aw_held && w_held && !s_axi_bvalid;
		if (s_axi_awvalid && s_axi_awready) begin
			next_aw_held = 1'b1;
			next_wr_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			next_w_held = 1'b1;
			next_wr_data = s_axi_wdata;
		end
		if (wr_fire) begin
			next_aw_held = 1'b0;
			next_w_held = 1'b0;
			next_bvalid = 1'b1;
			next_bresp = (wr_addr[1:0] == 2'h0 &&
				wr_addr <= dtcru_pkg::OFS_CAP_CTRL) ?
				dtcru_pkg::AXI_OKAY : dtcru_pkg::AXI_SLVERR;
		end
		if (s_axi_bvalid && s_axi_bready) begin
			next_bvalid = 1'b0;
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			wr_addr <= '0;
			wr_data <= '0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= dtcru_pkg::AXI_OKAY;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
		end else begin
			aw_held <= next_aw_held;
			w_held <= next_w_held;
			wr_addr <= next_wr_addr;
			wr_data <= next_wr_data;
			s_axi_bvalid <= next_bvalid;
			s_axi_bresp <= next_bresp;
			// Registered readies; low in reset and while an address or data beat is held
			s_axi_awready <= !next_aw_held;
			s_axi_wready <= !next_w_held;
		end
	end

	// AXI4-Lite read: one outstanding, answer one cycle after address
	logic next_rvalid;
	logic [31:0] next_rdata;
	logic [1:0] next_rresp;
	always_comb begin
		next_rvalid = s_axi_rvalid;
		next_rdata = s_axi_rdata;
		next_rresp = s_axi_rresp;
		if (s_axi_arvalid && s_axi_arready) begin
			next_rvalid = 1'b1;
			next_rresp = dtcru_pkg::AXI_OKAY;
			unique case (s_axi_araddr)
				dtcru_pkg::OFS_AUX_CTRL: next_rdata = {20'h0, aux.ctrl};
				dtcru_pkg::OFS_CORE_CTRL: next_rdata = {20'h0, core.ctrl};
				dtcru_pkg::OFS_AUX_CNT: next_rdata = {16'h0, aux.value};
				dtcru_pkg::OFS_CORE_CNT:
					next_rdata = {15'h0, toggle_latch, core.value};
				dtcru_pkg::OFS_CAPTURE_RELOAD_REG: next_rdata = {16'h0, capture_reload_reg};
				dtcru_pkg::OFS_CAP_CTRL: next_rdata = {27'h0, cap_ctrl};
				default: begin
					next_rdata = '0;
					next_rresp = dtcru_pkg::AXI_SLVERR;
				end
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			next_rvalid = 1'b0;
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= dtcru_pkg::AXI_OKAY;
			s_axi_arready <= 1'b0;
		end else begin
			s_axi_rvalid <= next_rvalid;
			s_axi_rdata <= next_rdata;
			s_axi_rresp <= next_rresp;
			s_axi_arready <= !next_rvalid;
		end
	end

	// Checks
	chk_toggle_flip: assert property (
		@(posedge aclk) disable iff (!aresetn)
		core_wrap |=> toggle_latch != $past(toggle_latch))
		else $error("toggle latch did not flip on wrap");
	chk_comp_pulse: assert property (
		@(posedge aclk) disable iff (!aresetn)
		core_wrap |=> compare_unit_clk)
		else $error("compare clock missing after wrap");
	chk_reload_load: assert property (
		@(posedge aclk) disable iff (!aresetn)
		core_wrap && core.ctrl[dtcru_pkg::F_RELOAD] && !wr_fire
		|=> core.value == $past(capture_reload_reg))
		else $error("reload value not loaded");
	chk_capture_copy: assert property (
		@(posedge aclk) disable iff (!aresetn)
		cap_ev && !wr_fire |=> capture_reload_reg == $past(aux.value))
		else $error("capture missed aux value");
	chk_capture_clear: assert property (
		@(posedge aclk) disable iff (!aresetn)
		cap_ev && cap_ctrl[dtcru_pkg::F_CCLR] && !wr_fire
		|=> aux.value == 16'h0000)
		else $error("aux not cleared after capture");
	chk_gate_hold: assert property (
		@(posedge aclk) disable iff (!aresetn)
		core.ctrl[dtcru_pkg::F_MODE +: 2] == 2'h1 && !wr_fire &&
		sync3[2] != core.ctrl[dtcru_pkg::F_GATEPOL]
		|=> core.value == $past(core.value))
		else $error("gated core counted while gate closed");
	chk_div4_rate: assert property (
		@(posedge aclk) disable iff (!aresetn)
		core_tick && core.ctrl[5:0] == 6'h20 |-> !$past(core_tick))
		else $error("divide by 4 ticked too often");
	chk_idle_stop: assert property (
		@(posedge aclk) disable iff (!aresetn)
		!core.ctrl[dtcru_pkg::F_RUN] && !wr_fire && !cap_ev
		|=> core.value == $past(core.value))
		else $error("stopped core timer moved");
endmodule : dtcru_top

//--- dtcru_cmp_model.sv
`timescale 1ns/1ps
// Compare-unit timer that advances once per core over/underflow pulse
module dtcru_cmp_model (
	input wire logic aclk, // Clock
	input wire logic aresetn, // Sync reset, low
	input wire logic tick, // Core over/underflow pulse
	output logic [15:0] count // Compare timer value
);
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			count <= 16'h0000;
		end else if (tick) begin
			count <= count + 16'h0001;
		end
	end
endmodule : dtcru_cmp_model

//--- testbench.sv
`timescale 1ns/1ps
module testbench;
	logic aclk = 1'h0;
	logic aresetn = 1'h0;
	logic [7:0] awaddr = 8'h00;
	logic [7:0] araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic awv = 1'h0, wv = 1'h0, bready = 1'h0, arv = 1'h0, rready = 1'h0;
	logic awrdy, wrdy, bvalid, arrdy, rvalid, tgl, cuc;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata, v;
	logic aux_in = 1'h0, aux_dir = 1'h0, core_in = 1'h0, core_dir = 1'h0;
	logic cap = 1'h0, pcnt = 1'h0, pdir = 1'h0;
	logic [15:0] cmp_cnt;
	int bad_count = 0;
	int cmp_count = 0;
	always #25 aclk = ~aclk;
	dtcru_top uut (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awv), .s_axi_awready(awrdy),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
		.s_axi_wready(wrdy), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arv),
		.s_axi_arready(arrdy), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.aux_input_pin(aux_in), .aux_direction_input_pin(aux_dir),
		.core_input_pin(core_in), .core_direction_input_pin(core_dir),
		.capture_input_pin(cap), .peer_count_input(pcnt),
		.peer_direction_input(pdir), .toggle_output_pin(tgl),
		.compare_unit_clk(cuc));
	dtcru_cmp_model cmp (.aclk(aclk), .aresetn(aresetn), .tick(cuc),
		.count(cmp_cnt));
	task automatic final_report;
		if (bad_count == 0 && cmp_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : final_report
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			bad_count++;
			$display("Error %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	function automatic logic [31:0] inr(input logic [31:0] x,
		input logic [31:0] lo, input logic [31:0] hi);
		return {31'h0, (x >= lo) && (x <= hi)};
	endfunction : inr
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] er);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awv <= 1'h1;
		wv <= 1'h1;
		bready <= 1'h1;
		do begin
			@(posedge aclk);
			if (awrdy) awv <= 1'h0;
			if (wrdy) wv <= 1'h0;
		end while (!bvalid);
		bready <= 1'h0;
		chk({30'h0, bresp}, {30'h0, er});
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [1:0] er,
		output logic [31:0] d);
		@(posedge aclk);
		araddr <= a;
		arv <= 1'h1;
		rready <= 1'h1;
		do begin
			@(posedge aclk);
			if (arrdy) arv <= 1'h0;
		end while (!rvalid);
		d = rdata;
		rready <= 1'h0;
		chk({30'h0, rresp}, {30'h0, er});
	endtask : rd
	// Counts include a few cycles of bus latency, hence range checks
	task automatic span(input logic [31:0] ctl, input logic [31:0] start,
		input int n, output logic [31:0] r);
		wr(dtcru_pkg::OFS_AUX_CNT, start, dtcru_pkg::AXI_OKAY);
		wr(dtcru_pkg::OFS_AUX_CTRL, ctl, dtcru_pkg::AXI_OKAY);
		repeat (n) @(posedge aclk);
		wr(dtcru_pkg::OFS_AUX_CTRL, ctl & 32'hffffffdf, dtcru_pkg::AXI_OKAY);
		rd(dtcru_pkg::OFS_AUX_CNT, dtcru_pkg::AXI_OKAY, r);
	endtask : span
	task automatic t_reset;
		chk({30'h0, tgl, cuc}, 32'h0);
		rd(dtcru_pkg::OFS_AUX_CTRL, dtcru_pkg::AXI_OKAY, v);
		chk(v, dtcru_pkg::CTRL_RST);
		rd(dtcru_pkg::OFS_CORE_CTRL, dtcru_pkg::AXI_OKAY, v);
		chk(v, dtcru_pkg::CTRL_RST);
		rd(8'h18, dtcru_pkg::AXI_SLVERR, v);
		chk(v, 32'h0);
		wr(8'h1c, 32'h1, dtcru_pkg::AXI_SLVERR);
	endtask : t_reset
	task automatic t_prescale;
		for (int c = 0; c < 8; c++) begin
			span(32'h20 | c, 32'h0, 2048, v);
			chk(inr(v, (2048 >> (c + 2)) - 1, (2048 >> (c + 2)) + 2), 1);
		end
	endtask : t_prescale
	task automatic t_dir;
		span(32'h60, 32'h100, 400, v);
		chk(inr(v, 32'h99, 32'h9d), 32'h1);
		@(posedge aclk);
		aux_dir <= 1'h1;
		span(32'he0, 32'h100, 400, v);
		chk(inr(v, 32'h163, 32'h167), 32'h1);
	endtask : t_dir
	task automatic t_gate;
		span(32'h128, 32'h0, 200, v);
		chk(v, 32'h0);
		@(posedge aclk);
		aux_in <= 1'h1;
		span(32'h128, 32'h0, 200, v);
		chk(inr(v, 32'h30, 32'h34), 32'h1);
	endtask : t_gate
	task automatic t_count;
		wr(dtcru_pkg::OFS_AUX_CNT, 32'h0, dtcru_pkg::AXI_OKAY);
		wr(dtcru_pkg::OFS_AUX_CTRL, 32'h30, dtcru_pkg::AXI_OKAY);
		for (int i = 0; i < 5; i++) begin
			repeat (6) @(posedge aclk);
			aux_in <= ~aux_in;
		end
		repeat (6) @(posedge aclk);
		rd(dtcru_pkg::OFS_AUX_CNT, dtcru_pkg::AXI_OKAY, v);
		chk(v, 32'h5);
		wr(dtcru_pkg::OFS_AUX_CTRL, 32'h0, dtcru_pkg::AXI_OKAY);
	endtask : t_count
	task automatic t_core;
		wr(dtcru_pkg::OFS_CORE_CNT, 32'hfffe, dtcru_pkg::AXI_OKAY);
		wr(dtcru_pkg::OFS_CAPTURE_RELOAD_REG, 32'h1234, dtcru_pkg::AXI_OKAY);
		wr(dtcru_pkg::OFS_CORE_CTRL, 32'hc20, dtcru_pkg::AXI_OKAY);
		repeat (16) @(posedge aclk);
		wr(dtcru_pkg::OFS_CORE_CTRL, 32'hc00, dtcru_pkg::AXI_OKAY);
		rd(dtcru_pkg::OFS_CORE_CNT, dtcru_pkg::AXI_OKAY, v);
		chk({31'h0, v[16]}, 32'h1);
		chk(inr({16'h0, v[15:0]}, 32'h1234, 32'h1237), 32'h1);
		chk({31'h0, tgl}, 32'h1);
		chk({16'h0, cmp_cnt}, 32'h1);
	endtask : t_core
	task automatic cap_exp(input logic [31:0] e);
		repeat (8) @(posedge aclk);
		rd(dtcru_pkg::OFS_CAPTURE_RELOAD_REG, dtcru_pkg::AXI_OKAY, v);
		chk(v, e);
	endtask : cap_exp
	task automatic t_cap;
		wr(dtcru_pkg::OFS_CAP_CTRL, 32'h11, dtcru_pkg::AXI_OKAY);
		wr(dtcru_pkg::OFS_AUX_CNT, 32'h500, dtcru_pkg::AXI_OKAY);
		cap <= 1'h1;
		cap_exp(32'h500);
		rd(dtcru_pkg::OFS_AUX_CNT, dtcru_pkg::AXI_OKAY, v);
		chk(v, 32'h0);
		wr(dtcru_pkg::OFS_CAP_CTRL, 32'h5, dtcru_pkg::AXI_OKAY);
		wr(dtcru_pkg::OFS_AUX_CNT, 32'h77, dtcru_pkg::AXI_OKAY);
		pcnt <= 1'h1;
		cap_exp(32'h77);
		wr(dtcru_pkg::OFS_AUX_CNT, 32'h88, dtcru_pkg::AXI_OKAY);
		// Falling edge of the capture pin is not selected now
		cap <= 1'h0;
		cap_exp(32'h77);
		wr(dtcru_pkg::OFS_CAP_CTRL, 32'h9, dtcru_pkg::AXI_OKAY);
		pdir <= 1'h1;
		cap_exp(32'h88);
	endtask : t_cap
	// Core wraps every second tick; aux counts each toggle latch edge
	task automatic t_chain;
		wr(dtcru_pkg::OFS_AUX_CNT, 32'h0, dtcru_pkg::AXI_OKAY);
		wr(dtcru_pkg::OFS_AUX_CTRL, 32'h230, dtcru_pkg::AXI_OKAY);
		wr(dtcru_pkg::OFS_CAPTURE_RELOAD_REG, 32'hfffe, dtcru_pkg::AXI_OKAY);
		wr(dtcru_pkg::OFS_CORE_CNT, 32'hfffe, dtcru_pkg::AXI_OKAY);
		wr(dtcru_pkg::OFS_CORE_CTRL, 32'h420, dtcru_pkg::AXI_OKAY);
		repeat (80) @(posedge aclk);
		wr(dtcru_pkg::OFS_CORE_CTRL, 32'h400, dtcru_pkg::AXI_OKAY);
		repeat (4) @(posedge aclk);
		rd(dtcru_pkg::OFS_AUX_CNT, dtcru_pkg::AXI_OKAY, v);
		chk(inr(v, 32'h9, 32'hb), 32'h1);
		chk(inr({16'h0, cmp_cnt}, 32'ha, 32'hc), 32'h1);
		chk({31'h0, tgl}, 32'h0);
		wr(dtcru_pkg::OFS_AUX_CTRL, 32'h0, dtcru_pkg::AXI_OKAY);
	endtask : t_chain
	task automatic t_core_gate;
		wr(dtcru_pkg::OFS_CORE_CNT, 32'h10, dtcru_pkg::AXI_OKAY);
		wr(dtcru_pkg::OFS_CORE_CTRL, 32'h128, dtcru_pkg::AXI_OKAY);
		repeat (40) @(posedge aclk);
		rd(dtcru_pkg::OFS_CORE_CNT, dtcru_pkg::AXI_OKAY, v);
		chk({16'h0, v[15:0]}, 32'h10);
		core_in <= 1'h1;
		repeat (40) @(posedge aclk);
		wr(dtcru_pkg::OFS_CORE_CTRL, 32'h0, dtcru_pkg::AXI_OKAY);
		rd(dtcru_pkg::OFS_CORE_CNT, dtcru_pkg::AXI_OKAY, v);
		chk(inr({16'h0, v[15:0]}, 32'h19, 32'h1b), 32'h1);
	endtask : t_core_gate
	initial begin
		repeat (3) @(posedge aclk);
		aresetn <= 1'h1;
		t_reset;
		t_prescale;
		t_dir;
		t_gate;
		t_count;
		t_core;
		t_cap;
		t_chain;
		t_core_gate;
		final_report;
	end
	initial begin
		repeat (40000) @(posedge aclk);
		bad_count++;
		final_report;
	end
endmodule : testbench
